/* rtl/asctl_pkg.sv */
package asctl_pkg;

    // ==========================================================
    // Geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int DEPTH  = 32768;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS      = 20;
    localparam int SELECT_ACCESS_NS   = 20;
    localparam int DRIVE_ACCESS_NS    = 8;
    localparam int SELECT_RELEASE_NS  = 5;
    localparam int DRIVE_RELEASE_NS   = 5;
    localparam int WRITE_FLOAT_NS     = 6;
    localparam int SELECT_WR_END_NS   = 12;
    localparam int ADDR_WR_END_NS     = 12;
    localparam int DATA_WR_END_NS     = 10;

    // ==========================================================
    // Derived counts
    function automatic int ceil_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ceil_cyc

    localparam int READ_WAIT_CYC  = ceil_cyc(SELECT_ACCESS_NS);
    localparam int FLOAT_CYC      = ceil_cyc(WRITE_FLOAT_NS);
    localparam int WR_PULSE_NS    = (SELECT_WR_END_NS > ADDR_WR_END_NS) ?
                                    SELECT_WR_END_NS : ADDR_WR_END_NS;
    localparam int WR_PULSE_CYC   = ceil_cyc(WR_PULSE_NS);
    localparam int DATA_SETUP_CYC = ceil_cyc(DATA_WR_END_NS);
    localparam int RELEASE_NS     = (SELECT_RELEASE_NS > DRIVE_RELEASE_NS) ?
                                    SELECT_RELEASE_NS : DRIVE_RELEASE_NS;
    localparam int RELEASE_CYC    = ceil_cyc(RELEASE_NS);
    localparam int CNT_W          = 4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_RD_WAIT, ST_RD_END, ST_WR_FLOAT, ST_WR_DATA, ST_TURN
    } asctl_state_t;

endpackage : asctl_pkg

/* rtl/asctl_pins_if.sv */
`timescale 1ns/1ps
interface asctl_pins_if;
    import asctl_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              sel_n;
    logic              wr_n;
    logic              drv_n;
    logic [DATA_W-1:0] dout;
    logic              dout_oe;
    modport ctl (output addr, sel_n, wr_n, drv_n, dout, dout_oe);
    modport pad (input  addr, sel_n, wr_n, drv_n, dout, dout_oe);
endinterface : asctl_pins_if

/* rtl/asctl_pad.sv */
`timescale 1ns/1ps
module asctl_pad
    import asctl_pkg::*;
(
    // Internal pin group
    asctl_pins_if.pad                 pins,
    // Device pins
    output logic [asctl_pkg::ADDR_W-1:0] mem_addr_o,
    output logic                         mem_sel_n_o,
    output logic                         mem_wr_n_o,
    output logic                         mem_drv_n_o,
    output logic [asctl_pkg::DATA_W-1:0] shared_data_lines_o,
    output logic                         shared_data_lines_oe_o
);
    assign mem_addr_o             = pins.addr;
    assign mem_sel_n_o            = pins.sel_n;
    assign mem_wr_n_o             = pins.wr_n;
    assign mem_drv_n_o            = pins.drv_n;
    // Drive data only while the write strobe is low
    assign shared_data_lines_o    = pins.dout;
    assign shared_data_lines_oe_o = pins.dout_oe & ~pins.wr_n; // RULE19
endmodule : asctl_pad

/* rtl/asctl_top.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Address changes only while chip select and write strobe are high.
// RULE2 - Write ends at the first rising edge of select or strobe.
// RULE3 - Write strobe stays high for a whole read.
// RULE4 - Select and output drive stay low during a read.
// RULE5 - Address is valid before select falls on a read.
// RULE6 - Memory delivers read data within select access delay.
// RULE7 - Memory drives data within drive access delay of drive falling.
// RULE8 - Memory holds old read data briefly after address change.
// RULE9 - Memory floats outputs shortly after select rises.
// RULE10 - Memory floats outputs shortly after drive rises.
// RULE11 - Memory floats outputs shortly after write strobe falls.
// RULE12 - Memory waits briefly after write end before driving again.
// RULE13 - Select stays low long enough before the write ends.
// RULE14 - Address is stable long enough before the write ends.
// RULE15 - Write data is valid long enough before the write ends.
// RULE16 - Select high puts memory in standby with floating outputs.
// RULE17 - Memory captures data at the write-ending rising edge.
// RULE18 - Array holds 32768 bytes on a fifteen-bit address.
// RULE19 - Controller drives data only after memory outputs are disabled.
module asctl_top
    import asctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                         clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         ce_i,
    // Request port
    input  wire logic                         req_valid_i,
    output logic                              req_ready_o,
    input  wire logic                         req_write_i,
    input  wire logic [asctl_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [asctl_pkg::DATA_W-1:0] req_wdata_i,
    // Read answer
    output logic                              rsp_valid_o,
    output logic [asctl_pkg::DATA_W-1:0]      rsp_rdata_o,
    // Memory pins
    output logic [asctl_pkg::ADDR_W-1:0]      mem_addr_o,
    output logic                              mem_sel_n_o,
    output logic                              mem_wr_n_o,
    output logic                              mem_drv_n_o,
    input  wire logic [asctl_pkg::DATA_W-1:0] shared_data_lines_i,
    output logic [asctl_pkg::DATA_W-1:0]      shared_data_lines_o,
    output logic                              shared_data_lines_oe_o
);
    import asctl_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        asctl_state_t      st;
        logic [CNT_W-1:0]  cnt;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              sel_n;
        logic              wr_n;
        logic              drv_n;
        logic              oe;
        logic              rsp_valid;
        logic [DATA_W-1:0] rdata;
    } asctl_regs_t;

    asctl_regs_t s_reg;
    asctl_regs_t s_next;

    localparam asctl_regs_t RESET_VAL = '{
        st: ST_IDLE, cnt: '0, write: 1'b0, addr: '0, wdata: '0,
        sel_n: 1'b1, wr_n: 1'b1, drv_n: 1'b1, oe: 1'b0,
        rsp_valid: 1'b0, rdata: '0
    };

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction : cyc

    // ==========================================================
    // Sequencer
    always_comb begin
        s_next           = s_reg;
        s_next.rsp_valid = 1'b0;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (req_valid_i) begin
                    // Address moves only with select and strobe high
                    s_next.addr  = req_addr_i; // RULE1
                    s_next.write = req_write_i;
                    s_next.wdata = req_wdata_i;
                    s_next.st    = ST_SETUP; // RULE5
                end
            end
            ST_SETUP: begin
                s_next.sel_n = 1'b0;
                if (s_reg.write) begin
                    s_next.wr_n = 1'b0;
                    s_next.cnt  = cyc(FLOAT_CYC);
                    s_next.st   = ST_WR_FLOAT;
                end else begin
                    s_next.wr_n  = 1'b1; // RULE3
                    s_next.drv_n = 1'b0; // RULE4
                    s_next.cnt   = cyc(READ_WAIT_CYC);
                    s_next.st    = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                if (s_reg.cnt == '0) begin
                    s_next.st = ST_RD_END;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_RD_END: begin
                // Sample after the access delay has passed
                s_next.rdata     = shared_data_lines_i; // RULE6
                s_next.rsp_valid = 1'b1;
                s_next.sel_n     = 1'b1;
                s_next.drv_n     = 1'b1;
                s_next.cnt       = cyc(RELEASE_CYC);
                s_next.st        = ST_TURN;
            end
            ST_WR_FLOAT: begin
                if (s_reg.cnt == '0) begin
                    // Memory outputs floated by the strobe
                    s_next.oe  = 1'b1; // RULE19
                    s_next.cnt = cyc((WR_PULSE_CYC > DATA_SETUP_CYC) ?
                                     WR_PULSE_CYC : DATA_SETUP_CYC);
                    s_next.st  = ST_WR_DATA;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            ST_WR_DATA: begin
                if (s_reg.cnt == '0) begin
                    // Strobe and select rise together to end the write
                    s_next.wr_n  = 1'b1; // RULE2
                    s_next.sel_n = 1'b1; // RULE13
                    s_next.cnt   = cyc(1);
                    s_next.st    = ST_TURN; // RULE14
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1; // RULE15
                end
            end
            ST_TURN: begin
                // Internal enable cleared; the pad already released the data lines at the write-ending edge
                s_next.oe = 1'b0;
                if (s_reg.cnt == '0) begin
                    s_next.st = ST_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            default: begin
                s_next = RESET_VAL;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg <= RESET_VAL;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    asctl_pins_if pins ();

    assign pins.addr   = s_reg.addr;
    assign pins.sel_n  = s_reg.sel_n;
    assign pins.wr_n   = s_reg.wr_n;
    assign pins.drv_n  = s_reg.drv_n;
    assign pins.dout   = s_reg.wdata;
    assign pins.dout_oe = s_reg.oe;

    assign req_ready_o = (s_reg.st == ST_IDLE) & ce_i;
    assign rsp_valid_o = s_reg.rsp_valid;
    assign rsp_rdata_o = s_reg.rdata;

    asctl_pad u_pad (
        .pins                   (pins),
        .mem_addr_o             (mem_addr_o),
        .mem_sel_n_o            (mem_sel_n_o),
        .mem_wr_n_o             (mem_wr_n_o),
        .mem_drv_n_o            (mem_drv_n_o),
        .shared_data_lines_o    (shared_data_lines_o),
        .shared_data_lines_oe_o (shared_data_lines_oe_o)
    );

endmodule : asctl_top

/* dv/asctl_monitor.sv */
`timescale 1ns/1ps
module asctl_monitor
    import asctl_pkg::*;
(
    // Watched ports
    input wire logic                         clk_i, sys_rst_i, ce_i,
    input wire logic                         req_valid_i, req_ready_o, req_write_i,
    input wire logic                         rsp_valid_o, mem_sel_n_o, mem_wr_n_o,
    input wire logic                         mem_drv_n_o, shared_data_lines_oe_o,
    input wire logic [asctl_pkg::ADDR_W-1:0] mem_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire tk = req_valid_i && req_ready_o && ce_i;
    a_addr_move: assert property (!$stable(mem_addr_o) |-> mem_sel_n_o || mem_wr_n_o)
        else $error("address moved during a write");
    a_rd_strobe: assert property (!mem_drv_n_o |-> mem_wr_n_o)
        else $error("strobe low during read");
    a_rd_select: assert property (!mem_drv_n_o |-> !mem_sel_n_o)
        else $error("select high during read");
    a_rd_addr: assert property ($fell(mem_sel_n_o) |-> $stable(mem_addr_o))
        else $error("address late for select");
    a_rd_answer: assert property (tk && !req_write_i |-> ##4 rsp_valid_o)
        else $error("read answer late");
    a_wr_pulse: assert property (tk && req_write_i |->
        ##2 (!mem_sel_n_o && !mem_wr_n_o)[*2] ##1 (mem_sel_n_o && mem_wr_n_o))
        else $error("write pulse wrong");
    a_wr_addr: assert property (tk && req_write_i |=> ##1 $stable(mem_addr_o)[*4])
        else $error("address moved in write");
    a_wr_data: assert property ($rose(mem_wr_n_o) |->
        $past(shared_data_lines_oe_o) && $past(!mem_wr_n_o, 2))
        else $error("write data setup short");
    a_drv_after_float: assert property (shared_data_lines_oe_o |-> $past(!mem_wr_n_o))
        else $error("data driven before memory floated");
    a_no_fight: assert property (shared_data_lines_oe_o |-> !mem_wr_n_o && mem_drv_n_o)
        else $error("data driven while memory may drive");
endmodule : asctl_monitor

/* dv/asctl_sram_model.sv */
`timescale 1ns/1ps
module asctl_sram_model
    import asctl_pkg::*;
#(
    parameter int ACC_NS  = 8,
    parameter int HOLD_NS = 3
)
(
    // Memory pins
    input wire logic [asctl_pkg::ADDR_W-1:0] addr_i,
    input wire logic                         sel_n_i, wr_n_i, drv_n_i, ctl_oe_i,
    input wire logic [asctl_pkg::DATA_W-1:0] ctl_d_i,
    output logic [asctl_pkg::DATA_W-1:0]     bus_o
);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] pend = 8'h00;
    logic [DATA_W-1:0] last_q = 8'h00;
    logic              pend_ok = 1'b0;
    logic              rd_en = 1'b0;
    logic [DATA_W-1:0] rd_q = 8'h00;
    wire rd_now = !sel_n_i && wr_n_i && !drv_n_i;
    always @(rd_now) rd_en <= #(rd_now ? ACC_NS : 5) rd_now;
    always @(negedge rd_en) last_q = mem[addr_i];
    // Old byte stays on the lines briefly after the address moves
    always @(addr_i or rd_en) rd_q <= #(HOLD_NS) mem[addr_i];
    always @* if (!sel_n_i && !wr_n_i && ctl_oe_i) begin
        pend = ctl_d_i;
        pend_ok = 1'b1;
    end
    always @(posedge wr_n_i or posedge sel_n_i) if (pend_ok) begin
        mem[addr_i] = pend;
        pend_ok = 1'b0;
    end
    // Released bus shows the inverse of the last byte read
    assign bus_o = ctl_oe_i ? ctl_d_i : rd_en ? rd_q : ~last_q;
endmodule : asctl_sram_model

/* dv/asctl_top_tb.sv */
`timescale 1ns/1ps
module asctl_top_tb;
    import asctl_pkg::*;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              ce_i = 1'b1;
    logic              req_valid_i = 1'b0;
    logic              req_write_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = 15'h0000;
    logic [DATA_W-1:0] req_wdata_i = 8'h00;
    logic [DATA_W-1:0] rsp_rdata_o, bus, dout;
    logic [ADDR_W-1:0] maddr;
    logic              req_ready_o, rsp_valid_o, sel_n, wr_n, drv_n, oe;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                n;
    always #10 clk_i = ~clk_i;
    asctl_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(maddr), .mem_sel_n_o(sel_n),
        .mem_wr_n_o(wr_n), .mem_drv_n_o(drv_n), .shared_data_lines_i(bus),
        .shared_data_lines_o(dout), .shared_data_lines_oe_o(oe));
    asctl_sram_model #(.ACC_NS(SELECT_ACCESS_NS)) mem_u (
        .addr_i(maddr), .sel_n_i(sel_n), .wr_n_i(wr_n),
        .drv_n_i(drv_n), .ctl_oe_i(oe), .ctl_d_i(dout), .bus_o(bus));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // Issue one request and, for a read, count edges until the answer
    task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
        int i;
        @(posedge clk_i);
        #2;
        req_valid_i = 1'b1;
        req_write_i = w;
        req_addr_i = a;
        req_wdata_i = d;
        for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #2;
        end
        @(posedge clk_i);
        #2;
        req_valid_i = 1'b0;
        n = 0;
        while (!w && n < 20 && rsp_valid_o !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (i == 20 || n == 20) begin
            bad_count++;
            wrap_up();
        end
    endtask : xfer
    task automatic test_reset;
        check(16'({sel_n, wr_n, drv_n, oe, rsp_valid_o, req_ready_o}), 16'h0039);
        $display("test reset done");
    endtask : test_reset
    task automatic test_edges;
        xfer(1'b1, 15'h7FFF, 8'hA5);
        check(16'(req_ready_o), 16'h0000);
        xfer(1'b1, 15'h0000, 8'h66);
        xfer(1'b0, 15'h7FFF, 8'h00);
        check(16'(rsp_rdata_o), 16'h00A5);
        check(16'(n), 16'(READ_WAIT_CYC + 2));
        xfer(1'b0, 15'h0000, 8'h00);
        check(16'(rsp_rdata_o), 16'h0066);
        $display("test edges done");
    endtask : test_edges
    task automatic test_b2b;
        xfer(1'b1, 15'h1234, 8'h3C);
        xfer(1'b1, 15'h1234, 8'hC3);
        xfer(1'b0, 15'h1234, 8'h00);
        check(16'(rsp_rdata_o), 16'h00C3);
        xfer(1'b0, 15'h1234, 8'h00);
        check(16'(rsp_rdata_o), 16'h00C3);
        $display("test back to back done");
    endtask : test_b2b
    // Enable low: request is not taken and select stays high
    task automatic test_freeze;
        @(posedge clk_i);
        #2;
        ce_i = 1'b0;
        req_valid_i = 1'b1;
        req_write_i = 1'b0;
        req_addr_i = 15'h1234;
        repeat (3) @(posedge clk_i);
        #2;
        check(16'({req_ready_o, sel_n}), 16'h0001);
        ce_i = 1'b1;
        req_valid_i = 1'b0;
        xfer(1'b0, 15'h1234, 8'h00);
        check(16'(rsp_rdata_o), 16'h00C3);
        check(16'(n), 16'(READ_WAIT_CYC + 2));
        $display("test freeze done");
    endtask : test_freeze
    initial begin
        repeat (16) @(posedge clk_i);
        #2;
        sys_rst_i = 1'b0;
        #1;
        test_reset();
        test_edges();
        test_b2b();
        test_freeze();
        wrap_up();
    end
endmodule : asctl_top_tb
bind asctl_top asctl_monitor mon_u (.*);
